//--- atcs_timer.sv
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - timer tick is enable from selected source
// - switching source may corrupt count, compare, control; here the switch leaves them as they stand
// - writes held, copied after second oscillator edge
// - separate temporary register per destination
// - busy flag high until transfer completes
// - compare match suppressed while count/compare pending
// - wake logic needs one oscillator cycle rearm
// - oscillator runs in async mode except power-down and standby
// - registers undefined after power-down or standby; here they keep their values
// - wake starts on next timer tick
// - count read via holding register per edge
// - flag sync three cycles plus timer cycle
// - compare pin driven from timer domain
// - source defaults to system clock, select switches
// - async select disconnects both oscillator pins
// - prescaler taps 1,8,32,64,128,256,1024 or stop
// - prescaler reset bit clears prescaler
// - clock select field encoding
module atcs_timer (
  input  wire logic        sys_clk,           // system clock, 125 MHz
  input  wire logic        sys_rst,           // synchronous reset, active high
  input  wire logic [4:0]  avs_address,       // byte address
  input  wire logic        avs_read,          // read strobe
  input  wire logic        avs_write,         // write strobe
  input  wire logic [31:0] avs_writedata,     // write data
  input  wire logic [3:0]  avs_byteenable,    // byte enables
  output logic [31:0]      avs_readdata,      // read data
  output logic             avs_waitrequest,   // stall
  output logic             avs_readdatavalid_unused, // tied low, reads answer with waitrequest
  input  wire logic        osc_input_pin,     // oscillator input level
  output logic             osc_output_pin,    // oscillator drive back to crystal
  output logic             osc_pins_port_en,  // high while pins serve general port
  output logic             osc_enable,        // oscillator running
  output logic             compare_out,       // compare output pin
  output logic             irq_wake,          // wake request to power control
  output logic             irq_out            // enabled flag pending
);
  typedef struct packed {
    logic [7:0]  count;        // timer_count
    logic [7:0]  compare;      // compare_value
    logic [7:0]  control;      // timer_control (clock select in low bits)
    logic [7:0]  tmp_count;    // temporary for count write
    logic [7:0]  tmp_compare;  // temporary for compare write
    logic [7:0]  tmp_control;  // temporary for control write
    logic        ub_count;     // count_update_busy
    logic        ub_compare;   // compare_update_busy
    logic        ub_control;   // control_update_busy
    logic [1:0]  ec_count;     // oscillator edges seen while pending
    logic [1:0]  ec_compare;
    logic [1:0]  ec_control;
    logic        asel;         // async_clock_select
    logic [9:0]  pre;          // prescaler counter
    logic [7:0]  hold;         // count holding register
    logic        ovf_ie;       // overflow_irq_enable
    logic        cmp_ie;       // compare_irq_enable
    logic        ovf_fl;       // overflow flag
    logic        cmp_fl;       // compare_match_flag
    logic        ovf_pend;     // timer-side overflow event
    logic        cmp_pend;     // timer-side compare event
    logic [1:0]  fsync;        // processor cycles of flag sync
    logic        wake_pend;    // condition seen, wake on next tick
    logic        wake;         // wake request
    logic        wake_armed;   // rearmed after one oscillator cycle
    logic [2:0]  sleep;        // sleep mode
    logic        cmp_pin;      // compare output level
    logic        blk_cmp;      // compare blocked on next tick
    logic        waitq;        // one stall cycle for reads
  } atcs_st_t;

  atcs_st_t st_r;    // state
  atcs_st_t st_nxt;  // next state

  logic osc_rise;    // rising oscillator edge pulse
  logic src_en;      // timer_source_clock enable
  logic tick;        // timer clock enable
  logic acc;         // bus access in progress
  logic [3:0] idx;   // register index

  // oscillator edge detector
  atcs_edge u_edge (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .osc_in   (osc_input_pin),
    .osc_rise (osc_rise)
  );

  // prescaler tap selection
  function automatic logic tap(input logic [2:0] cs, input logic [9:0] p, input logic en);
    logic r;
    r = 1'b0;
    unique case (cs)
      3'h0: r = 1'b0;
      3'h1: r = en;
      3'h2: r = en & (p[2:0] == 3'h7);
      3'h3: r = en & (p[4:0] == 5'h1f);
      3'h4: r = en & (p[5:0] == 6'h3f);
      3'h5: r = en & (p[6:0] == 7'h7f);
      3'h6: r = en & (p[7:0] == 8'hff);
      3'h7: r = en & (p == 10'h3ff);
    endcase
    return r;
  endfunction

  // pending-write edge count: two edges complete a transfer
  function automatic logic [1:0] edge_step(input logic busy, input logic [1:0] c, input logic e);
    logic [1:0] r;
    r = c;
    if (busy && e) begin
      r = c + 2'h1;
    end
    return r;
  endfunction

  // source enable: system clock or oscillator edges
  assign src_en = st_r.asel ? osc_rise : 1'b1;
  assign tick   = tap(st_r.control[2:0], st_r.pre, src_en);
  assign acc    = avs_read | avs_write;
  assign idx    = avs_address[4:1] >> 1;

  // next-state logic
  always_comb begin
    logic       wr;
    logic       match;
    logic       ovf;
    logic       done_cnt;
    logic       done_cmp;
    logic       done_ctl;
    logic [7:0] nxt_cnt;
    wr       = 1'b0;
    match    = 1'b0;
    ovf      = 1'b0;
    done_cnt = 1'b0;
    done_cmp = 1'b0;
    done_ctl = 1'b0;
    nxt_cnt  = 8'h00;
    st_nxt   = st_r;
    wr       = avs_write & ~avs_waitrequest & avs_byteenable[0];
    // read stall toggles once per read
    st_nxt.waitq = avs_read & ~st_r.waitq;
    // prescaler advance on source enable
    if (src_en) begin
      st_nxt.pre = st_r.pre + 10'h001;
    end
    // counter advance and compare
    if (tick) begin
      nxt_cnt  = st_r.count + 8'h01;
      ovf      = (st_r.count == 8'hff);
      match    = (st_r.count == st_r.compare) && !st_r.blk_cmp
                 && !st_r.ub_count && !st_r.ub_compare;
      st_nxt.count   = nxt_cnt;
      st_nxt.blk_cmp = 1'b0;
      if (match) begin
        st_nxt.cmp_pin  = ~st_r.cmp_pin;
        st_nxt.cmp_pend = 1'b1;
      end
      if (ovf) begin
        st_nxt.ovf_pend = 1'b1;
      end
      // wake fires the tick after the condition
      if (st_r.wake_pend) begin
        st_nxt.wake      = 1'b1;
        st_nxt.wake_pend = 1'b0;
      end
      if ((match && st_r.cmp_ie) || (ovf && st_r.ovf_ie)) begin
        st_nxt.wake_pend = st_r.wake_armed;
        st_nxt.wake_armed = 1'b0;
      end
    end
    // wake logic rearms after one oscillator cycle without sleep
    if (osc_rise && !st_r.wake_armed && st_r.sleep == atcs_pkg::SLP_NONE) begin
      st_nxt.wake_armed = 1'b1;
      st_nxt.wake       = 1'b0;
    end
    // flag sync: timer-side event then three processor cycles
    if (st_r.ovf_pend || st_r.cmp_pend) begin
      st_nxt.fsync = st_r.fsync + 2'h1;
      if (st_r.fsync == 2'(atcs_pkg::FLAG_SYNC_CYC - 1)) begin
        st_nxt.fsync    = 2'h0;
        st_nxt.ovf_fl   = st_r.ovf_fl | st_r.ovf_pend;
        st_nxt.cmp_fl   = st_r.cmp_fl | st_r.cmp_pend;
        st_nxt.ovf_pend = 1'b0;
        st_nxt.cmp_pend = 1'b0;
      end
    end
    // holding register refresh per oscillator edge in async mode, every cycle in sync mode
    if (!st_r.asel || osc_rise) begin
      st_nxt.hold = st_nxt.count;
    end
    // pending transfers: count edges in async mode
    st_nxt.ec_count   = edge_step(st_r.ub_count, st_r.ec_count, osc_rise);
    st_nxt.ec_compare = edge_step(st_r.ub_compare, st_r.ec_compare, osc_rise);
    st_nxt.ec_control = edge_step(st_r.ub_control, st_r.ec_control, osc_rise);
    done_cnt = st_r.ub_count && (st_r.ec_count == 2'h2);
    done_cmp = st_r.ub_compare && (st_r.ec_compare == 2'h2);
    done_ctl = st_r.ub_control && (st_r.ec_control == 2'h2);
    if (done_cnt) begin
      st_nxt.count    = st_r.tmp_count;
      st_nxt.blk_cmp  = 1'b1;
      st_nxt.ub_count = 1'b0;
      st_nxt.ec_count = 2'h0;
    end
    if (done_cmp) begin
      st_nxt.compare    = st_r.tmp_compare;
      st_nxt.ub_compare = 1'b0;
      st_nxt.ec_compare = 2'h0;
    end
    if (done_ctl) begin
      st_nxt.control    = st_r.tmp_control;
      st_nxt.ub_control = 1'b0;
      st_nxt.ec_control = 2'h0;
    end
    // register writes
    if (wr) begin
      unique case (idx)
        atcs_pkg::OFS_COUNT: begin
          if (st_r.asel) begin
            st_nxt.tmp_count = avs_writedata[7:0];
            st_nxt.ub_count  = 1'b1;
            st_nxt.ec_count  = 2'h0;
          end else begin
            st_nxt.count   = avs_writedata[7:0];
            st_nxt.blk_cmp = 1'b1;
          end
        end
        atcs_pkg::OFS_COMPARE: begin
          if (st_r.asel) begin
            st_nxt.tmp_compare = avs_writedata[7:0];
            st_nxt.ub_compare  = 1'b1;
            st_nxt.ec_compare  = 2'h0;
          end else begin
            st_nxt.compare = avs_writedata[7:0];
          end
        end
        atcs_pkg::OFS_CONTROL: begin
          if (st_r.asel) begin
            st_nxt.tmp_control = avs_writedata[7:0];
            st_nxt.ub_control  = 1'b1;
            st_nxt.ec_control  = 2'h0;
          end else begin
            st_nxt.control = avs_writedata[7:0];
          end
        end
        atcs_pkg::OFS_ASYNC: begin
          // source switch leaves timer registers as they stand
          st_nxt.asel = avs_writedata[atcs_pkg::BIT_ASEL];
        end
        atcs_pkg::OFS_SFR: begin
          if (avs_writedata[atcs_pkg::BIT_PSR]) begin
            st_nxt.pre = 10'h000;
          end
        end
        atcs_pkg::OFS_IRQ: begin
          st_nxt.ovf_ie = avs_writedata[atcs_pkg::BIT_OVF_IE];
          st_nxt.cmp_ie = avs_writedata[atcs_pkg::BIT_CMP_IE];
          // write one clears, a same-cycle set wins
          if (avs_writedata[atcs_pkg::BIT_OVF_FL] && !st_nxt.ovf_fl) begin
            st_nxt.ovf_fl = 1'b0;
          end else if (avs_writedata[atcs_pkg::BIT_OVF_FL] && !(st_r.ovf_pend && st_nxt.fsync == 2'h0)) begin
            st_nxt.ovf_fl = 1'b0;
          end
          if (avs_writedata[atcs_pkg::BIT_CMP_FL] && !(st_r.cmp_pend && st_nxt.fsync == 2'h0)) begin
            st_nxt.cmp_fl = 1'b0;
          end
        end
        atcs_pkg::OFS_SLEEP: begin
          st_nxt.sleep = avs_writedata[2:0];
          if (avs_writedata[2:0] == atcs_pkg::SLP_NONE) begin
            st_nxt.wake = 1'b0;
          end
        end
        default: begin
          // unmapped: ignored
        end
      endcase
    end
  end

  // register state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r            <= '0;
      st_r.wake_armed <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // read data mux, registered via stall cycle
  logic [31:0] rd_r;   // registered read data
  logic [31:0] rd_nxt; // next read data
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (idx)
      atcs_pkg::OFS_COUNT:   rd_nxt = {24'h000000, st_r.hold};
      atcs_pkg::OFS_COMPARE: rd_nxt = {24'h000000, st_r.compare};
      atcs_pkg::OFS_CONTROL: rd_nxt = {24'h000000, st_r.control};
      atcs_pkg::OFS_ASYNC:   rd_nxt = {28'h0000000, st_r.asel, st_r.ub_count,
                                       st_r.ub_compare, st_r.ub_control};
      atcs_pkg::OFS_IRQ:     rd_nxt = {28'h0000000, st_r.cmp_fl, st_r.ovf_fl,
                                       st_r.cmp_ie, st_r.ovf_ie};
      atcs_pkg::OFS_SLEEP:   rd_nxt = {29'h0000000, st_r.sleep};
      default:               rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_r <= 32'h0000_0000;
    end else if (avs_read && !st_r.waitq) begin
      rd_r <= rd_nxt;
    end
  end

  assign avs_readdata             = rd_r;
  assign avs_waitrequest          = avs_read & ~st_r.waitq;
  assign avs_readdatavalid_unused = 1'b0;
  // oscillator gating by sleep mode
  assign osc_enable       = st_r.asel && st_r.sleep != atcs_pkg::SLP_PDOWN
                            && st_r.sleep != atcs_pkg::SLP_STANDBY;
  assign osc_output_pin   = osc_enable & ~osc_input_pin;
  assign osc_pins_port_en = ~st_r.asel;
  assign compare_out      = st_r.cmp_pin;
  assign irq_wake         = st_r.wake;
  assign irq_out          = (st_r.ovf_fl & st_r.ovf_ie) | (st_r.cmp_fl & st_r.cmp_ie);
  logic unused_acc;
  assign unused_acc = acc;
endmodule

//--- atcs_pkg.sv
package atcs_pkg;
  // register word offsets (byte address = index * 4)
  localparam logic [3:0] OFS_COUNT   = 4'h0;  // timer_count
  localparam logic [3:0] OFS_COMPARE = 4'h1;  // compare_value
  localparam logic [3:0] OFS_CONTROL = 4'h2;  // timer_control
  localparam logic [3:0] OFS_ASYNC   = 4'h3;  // async_status_register
  localparam logic [3:0] OFS_SFR     = 4'h4;  // special_function_register
  localparam logic [3:0] OFS_IRQ     = 4'h5;  // irq enables and flags
  localparam logic [3:0] OFS_SLEEP   = 4'h6;  // sleep mode control
  // async status field positions
  localparam int BIT_CTL_UB  = 0;  // control_update_busy
  localparam int BIT_CMP_UB  = 1;  // compare_update_busy
  localparam int BIT_CNT_UB  = 2;  // count_update_busy
  localparam int BIT_ASEL    = 3;  // async_clock_select
  // special function register field
  localparam int BIT_PSR     = 1;  // prescaler_reset_bit
  // irq register fields
  localparam int BIT_OVF_IE  = 0;  // overflow_irq_enable
  localparam int BIT_CMP_IE  = 1;  // compare_irq_enable
  localparam int BIT_OVF_FL  = 2;  // overflow flag
  localparam int BIT_CMP_FL  = 3;  // compare_match_flag
  // sleep mode encodings
  localparam logic [2:0] SLP_NONE    = 3'h0;
  localparam logic [2:0] SLP_PSAVE   = 3'h3;
  localparam logic [2:0] SLP_PDOWN   = 3'h2;
  localparam logic [2:0] SLP_STANDBY = 3'h6;
  localparam logic [2:0] SLP_EXTSTBY = 3'h7;
  // reset values
  localparam logic [7:0] RST_BYTE    = 8'h00;
  // flag sync in processor cycles after the timer event
  localparam int FLAG_SYNC_CYC = 3;
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  // prescaler width, enough for divide by 1024
  localparam int PRE_W = 10;
endpackage

//--- atcs_edge.sv
`timescale 1ns/1ps
// synchronises the oscillator input and marks each rising edge
module atcs_edge (
  input  wire logic sys_clk,    // system clock
  input  wire logic sys_rst,    // synchronous reset
  input  wire logic osc_in,     // raw oscillator level
  output logic      osc_rise    // one-cycle pulse per rising edge
);
  typedef struct packed {
    logic s1;   // first sync stage
    logic s2;   // second sync stage
    logic s3;   // delayed copy for edge detect
  } atcs_edge_st_t;

  atcs_edge_st_t st_r;   // state
  atcs_edge_st_t st_nxt; // next state

  // shift chain
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = osc_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  // register state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign osc_rise = st_r.s2 & ~st_r.s3;
endmodule

//--- atcs_osc_model.sv
`timescale 1ns/1ps
// crystal stand-in: toggles only while the device keeps it running
module atcs_osc_model #(
  parameter int HALF = 8  // sys cycles per half period
) (
  input  wire logic sys_clk,       // bench time base
  input  wire logic osc_enable,    // device run request
  output logic      osc_input_pin  // oscillator level
);
  int cnt = 0;  // half period counter, known before the first enable
  initial osc_input_pin = 1'b0;
  // stopped crystal stands still low
  always @(posedge sys_clk) begin
    if (!osc_enable) begin
      cnt <= 0;
      osc_input_pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      osc_input_pin <= ~osc_input_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

//--- atcs_timer_monitor.sv
`timescale 1ns/1ps
// port level checks on the timer block
module atcs_timer_monitor (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        osc_input_pin,
  input wire logic        osc_output_pin,
  input wire logic        osc_pins_port_en,
  input wire logic        osc_enable,
  input wire logic        compare_out,
  input wire logic        irq_wake,
  input wire logic        irq_out
);
  logic [2:0] idx;  // word index
  logic       wr;   // accepted write
  assign idx = avs_address[4:2];
  assign wr  = avs_write & avs_byteenable[0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_reset_dflt: assert property (disable iff (1'b0) sys_rst |=>
    osc_pins_port_en && !compare_out && !irq_wake && !irq_out) else $error("outputs not at reset level");
  chk_pins_select: assert property ((wr && idx == 3'h3) |=>
    osc_pins_port_en == !$past(avs_writedata[3])) else $error("port enable does not follow select");
  chk_psave_run: assert property ((wr && idx == 3'h6 && avs_writedata[1:0] == 2'h3 &&
    osc_enable && !osc_pins_port_en) |=> osc_enable[*4]) else $error("oscillator stopped in save mode");
  chk_pdown_stop: assert property ((wr && idx == 3'h6 && avs_writedata[1:0] == 2'h2) |->
    ##[1:4] !osc_enable) else $error("oscillator still on in power down");
  chk_osc_drive: assert property ((osc_enable && $stable(osc_input_pin))[*4] |->
    osc_output_pin != osc_input_pin) else $error("oscillator drive not inverted");
  chk_cmp_block: assert property ((wr && (idx == 3'h0 || idx == 3'h1) && !osc_pins_port_en) |->
    ##2 $stable(compare_out)[*6]) else $error("compare output moved while write pending");
  chk_irq_gate: assert property ((wr && idx == 3'h5 && avs_writedata[1:0] == 2'h0) |=>
    !irq_out) else $error("interrupt with enables cleared");
  chk_rd_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer timing wrong");
  chk_wr_nowait: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
  cover property (wr && idx == 3'h3 && avs_writedata[3]);
  cover property (avs_read && !avs_waitrequest);
  cover property ($fell(osc_enable));
  cover property ($rose(irq_wake));
endmodule
bind atcs_timer atcs_timer_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .osc_input_pin(osc_input_pin), .osc_output_pin(osc_output_pin),
  .osc_pins_port_en(osc_pins_port_en), .osc_enable(osc_enable), .compare_out(compare_out),
  .irq_wake(irq_wake), .irq_out(irq_out));

//--- async_timer_clock_sync_tb.sv
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin error_cnt++; $display("[FAIL] %0t %s", $time, m); end end
// self-checking bench: software side by tasks, crystal by model
module async_timer_clock_sync_tb;
  localparam int OSC_PER = 16;  // oscillator period in sys cycles
  logic        sys_clk, sys_rst, avs_read, avs_write, osc_input_pin;
  logic [4:0]  avs_address;     // byte address
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest, osc_output_pin, osc_pins_port_en, osc_enable, compare_out, irq_wake, irq_out;
  int          error_cnt, n_tests, cyc;  // counters and cycle stamp
  atcs_timer DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_readdatavalid_unused(),
    .osc_input_pin(osc_input_pin), .osc_output_pin(osc_output_pin), .osc_pins_port_en(osc_pins_port_en),
    .osc_enable(osc_enable), .compare_out(compare_out), .irq_wake(irq_wake), .irq_out(irq_out));
  atcs_osc_model #(.HALF(OSC_PER / 2)) u_osc (.sys_clk(sys_clk), .osc_enable(osc_enable),
    .osc_input_pin(osc_input_pin));
  // clock and cycle stamp
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // write one register, waitrequest sampled each edge
  task automatic bus_wr(input logic [3:0] idx, input logic [7:0] d);
    int k;
    avs_address <= {idx[2:0], 2'h0};
    avs_writedata <= {24'h000000, d};
    avs_write <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    avs_write <= 1'b0;
    @(posedge sys_clk);
    if (k == 20) begin error_cnt++; $display("[FAIL] %0t write hang", $time); summarize(); end
  endtask
  // read one register, data taken at the accepting edge
  task automatic bus_rd(input logic [3:0] idx, output logic [7:0] d);
    int k;
    avs_address <= {idx[2:0], 2'h0};
    avs_read <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    d = avs_readdata[7:0];
    `CHK(avs_readdata[31:8], 24'h000000, "upper read bits")
    avs_read <= 1'b0;
    @(posedge sys_clk);
    if (k == 20) begin error_cnt++; $display("[FAIL] %0t read hang", $time); summarize(); end
  endtask
  // poll until all update busy flags are clear
  task automatic wait_ub;
    logic [7:0] d;
    for (int k = 0; k < 100; k++) begin
      bus_rd(atcs_pkg::OFS_ASYNC, d);
      if (d[2:0] === 3'h0) return;
    end
    error_cnt++;
    $display("[FAIL] %0t busy never cleared", $time);
    summarize();
  endtask
  // reset values, unmapped index reads zero
  task automatic t_reset;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      bus_rd(i[3:0], d);
      `CHK(d, 8'h00, "reset value")
    end
    `CHK(osc_pins_port_en, 1'b1, "pins free after reset")
    $display("t_reset done");
  endtask
  // every clock select code in synchronous mode, timed by overflow
  task automatic t_prescale;
    logic [7:0] d;
    int t0;
    int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    for (int c = 1; c < 8; c++) begin
      bus_wr(atcs_pkg::OFS_CONTROL, 8'h00);
      bus_wr(atcs_pkg::OFS_COUNT, 8'hf0);
      bus_wr(atcs_pkg::OFS_IRQ, 8'h0d);
      bus_wr(atcs_pkg::OFS_SFR, 8'h02);
      bus_wr(atcs_pkg::OFS_CONTROL, c[7:0]);
      t0 = cyc;
      d = 8'h00;
      while (d[2] !== 1'b1 && cyc - t0 < 17 * divs[c] + 40) bus_rd(atcs_pkg::OFS_IRQ, d);
      `CHK(d[2], 1'b1, "overflow not reached")
      `CHK(cyc - t0 >= 15 * divs[c], 1'b1, "tick faster than selected")
      `CHK(irq_out, 1'b1, "enabled flag not signalled")
    end
    bus_wr(atcs_pkg::OFS_CONTROL, atcs_pkg::CS_STOP);
    bus_wr(atcs_pkg::OFS_COUNT, 8'hff);
    bus_wr(atcs_pkg::OFS_IRQ, 8'h0c);
    repeat (300) @(posedge sys_clk);
    bus_rd(atcs_pkg::OFS_IRQ, d);
    `CHK(d[2], 1'b0, "stopped timer overflowed")
    $display("t_prescale done");
  endtask
  // asynchronous writes through temporary registers
  task automatic t_async;
    logic [7:0] d, c1, c2;
    int t0;
    bus_wr(atcs_pkg::OFS_IRQ, 8'h0c);
    bus_wr(atcs_pkg::OFS_ASYNC, 8'h08);
    `CHK(osc_pins_port_en, 1'b0, "pins not taken")
    repeat (4 * OSC_PER) @(posedge sys_clk);
    bus_wr(atcs_pkg::OFS_COMPARE, 8'h5a);
    t0 = cyc;
    bus_wr(atcs_pkg::OFS_CONTROL, {5'h00, atcs_pkg::CS_DIV1});
    bus_rd(atcs_pkg::OFS_ASYNC, d);
    `CHK(d[3:0], 4'hb, "busy flags after two writes")
    wait_ub();
    `CHK(cyc - t0 >= OSC_PER, 1'b1, "copied before second edge")
    bus_rd(atcs_pkg::OFS_COMPARE, d);
    `CHK(d, 8'h5a, "compare not copied")
    bus_rd(atcs_pkg::OFS_CONTROL, d);
    `CHK(d, 8'h01, "control not copied")
    bus_wr(atcs_pkg::OFS_COUNT, 8'h10);
    wait_ub();
    bus_wr(atcs_pkg::OFS_COMPARE, 8'h5a);
    wait_ub();
    bus_rd(atcs_pkg::OFS_COUNT, c1);
    `CHK(c1 >= 8'h10 && c1 <= 8'h18, 1'b1, "count after write")
    repeat (4 * OSC_PER) @(posedge sys_clk);
    bus_rd(atcs_pkg::OFS_COUNT, c2);
    `CHK(c2 - c1 >= 8'h03 && c2 - c1 <= 8'h05, 1'b1, "count not following oscillator")
    $display("t_async done");
  endtask
  // oscillator run state in every sleep mode
  task automatic t_sleep;
    logic [2:0] m[5] = '{atcs_pkg::SLP_PSAVE, atcs_pkg::SLP_EXTSTBY, atcs_pkg::SLP_PDOWN,
                         atcs_pkg::SLP_STANDBY, atcs_pkg::SLP_NONE};
    logic       e[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++) begin
      bus_wr(atcs_pkg::OFS_SLEEP, {5'h00, m[i]});
      repeat (20) @(posedge sys_clk);
      `CHK(osc_enable, e[i], "oscillator run state")
    end
    $display("t_sleep done");
  endtask
  // compare match wakes the device from power-save
  task automatic t_wake;
    logic [7:0] c;
    logic       p;
    int         k;
    bus_rd(atcs_pkg::OFS_COUNT, c);
    bus_wr(atcs_pkg::OFS_COMPARE, c + 8'h08);
    wait_ub();
    bus_wr(atcs_pkg::OFS_IRQ, 8'h0e);
    p = compare_out;
    bus_wr(atcs_pkg::OFS_SLEEP, {5'h00, atcs_pkg::SLP_PSAVE});
    for (k = 0; k < 20 * OSC_PER && irq_wake !== 1'b1; k++) @(posedge sys_clk);
    `CHK(irq_wake, 1'b1, "no wake from compare match")
    `CHK(compare_out, ~p, "compare pin did not toggle")
    `CHK(irq_out, 1'b1, "compare flag not synchronised")
    bus_wr(atcs_pkg::OFS_SLEEP, {5'h00, atcs_pkg::SLP_NONE});
    `CHK(irq_wake, 1'b0, "wake not dropped on leaving sleep")
    bus_wr(atcs_pkg::OFS_IRQ, 8'h0c);
    `CHK(irq_out, 1'b0, "flag or enable not cleared")
    $display("t_wake done");
  endtask
  // return to the system clock by the safe sequence
  task automatic t_back;
    logic [7:0] d;
    bus_wr(atcs_pkg::OFS_IRQ, 8'h0c);
    bus_wr(atcs_pkg::OFS_ASYNC, 8'h00);
    `CHK(osc_pins_port_en, 1'b1, "pins not released")
    bus_wr(atcs_pkg::OFS_COUNT, 8'h00);
    bus_wr(atcs_pkg::OFS_COMPARE, 8'h33);
    bus_wr(atcs_pkg::OFS_CONTROL, 8'h00);
    avs_byteenable <= 4'he;
    bus_wr(atcs_pkg::OFS_COMPARE, 8'h77);
    avs_byteenable <= 4'hf;
    bus_rd(atcs_pkg::OFS_COMPARE, d);
    `CHK(d, 8'h33, "direct write in sync mode")
    $display("t_back done");
  endtask
  // main sequence
  initial begin
    {sys_rst, avs_read, avs_write} = 3'h4;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    {error_cnt, n_tests, cyc} = 0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_prescale();
    t_async();
    t_sleep();
    t_wake();
    t_back();
    summarize();
  end
endmodule
